// ### logic/compact_timer.sv
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module compact_timer (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write
    input  wire logic [ctm_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // axi4-lite read
    input  wire logic [ctm_pkg::ADDR_W-1:0] araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // timer pins
    input  wire logic [1:0]                external_clock_pin,
    input  wire logic                      sub_clock_pin,
    output logic [1:0]                     timer_output_pin,
    output logic [1:0]                     timer_output_pin_inverted,
    // match requests
    output logic [1:0]                     compare_a_irq,
    output logic [1:0]                     period_irq
);
    typedef struct packed {
        logic [7:0]      awaddr;
        logic            aw_held;
        logic [7:0]      wbyte;
        logic            wlane0;
        logic            w_held;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [7:0]      rbyte;
        logic [1:0][7:0] ctl0;
        logic [1:0][7:0] ctl1;
        logic [1:0][7:0] hold;
        logic [1:0][9:0] cmpa;
    } bus_s;

    localparam bus_s BUS_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    bus_s       r_reg;
    bus_s       r_next;
    logic [9:0] cnt_w [2];
    logic       wr_go;
    logic       wr_t;
    logic [2:0] wr_idx;
    logic       rd_go;
    logic       rd_t;
    logic [2:0] rd_idx;

    // =========================================================
    // address decode
    // =========================================================
    function automatic logic addr_ok(input logic [7:0] a);
        return (a[7:6] == 2'h0) && (a[1:0] == 2'h0) && (a[4:2] <= ctm_pkg::REG_CMPA_HI);
    endfunction

    // =========================================================
    // timer copies
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < ctm_pkg::TIMERS; g++) begin : gen_timer
            timer_if tif ();
            assign tif.ctl0 = r_reg.ctl0[g];
            assign tif.ctl1 = r_reg.ctl1[g];
            assign tif.cmpa = r_reg.cmpa[g];
            assign cnt_w[g] = tif.cnt;
            assign timer_output_pin[g]          = tif.pin;
            assign timer_output_pin_inverted[g] = tif.pin_n;
            assign compare_a_irq[g]             = tif.irq_a;
            assign period_irq[g]                = tif.irq_p;
            timer_core u_core (
                .aclk        (aclk),
                .aresetn     (aresetn),
                .ext_clk_pin (external_clock_pin[g]),
                .sub_clk_pin (sub_clock_pin),
                .tif         (tif.core)
            );
        end
    endgenerate

    // =========================================================
    // bus slave and register file
    // =========================================================
    always_comb begin
        r_next = r_reg;
        wr_go  = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
        wr_t   = r_reg.awaddr[5];
        wr_idx = r_reg.awaddr[4:2];
        rd_go  = arvalid && r_reg.arready;
        rd_t   = araddr[5];
        rd_idx = araddr[4:2];
        if (awvalid && r_reg.awready) begin
            r_next.awaddr  = awaddr;
            r_next.aw_held = 1'b1;
        end
        if (wvalid && r_reg.wready) begin
            r_next.wbyte   = wdata[7:0];
            r_next.wlane0  = wstrb[0];
            r_next.w_held  = 1'b1;
        end
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end
        if (rd_go) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = addr_ok(araddr) ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
            r_next.rbyte  = 8'h00;
            if (addr_ok(araddr)) begin
                unique case (rd_idx)
                    ctm_pkg::REG_CTL0:    r_next.rbyte = r_reg.ctl0[rd_t];
                    ctm_pkg::REG_CTL1:    r_next.rbyte = r_reg.ctl1[rd_t];
                    ctm_pkg::REG_CNT_HI: begin
                        r_next.rbyte        = {6'h00, cnt_w[rd_t][9:8]};
                        r_next.hold[rd_t]   = cnt_w[rd_t][7:0];
                    end
                    ctm_pkg::REG_CMPA_HI: begin
                        r_next.rbyte        = {6'h00, r_reg.cmpa[rd_t][9:8]};
                        r_next.hold[rd_t]   = r_reg.cmpa[rd_t][7:0];
                    end
                    default:              r_next.rbyte = r_reg.hold[rd_t];
                endcase
            end
        end
        if (wr_go) begin
            r_next.bvalid  = 1'b1;
            r_next.aw_held = 1'b0;
            r_next.w_held  = 1'b0;
            r_next.bresp   = addr_ok(r_reg.awaddr) ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
            if (addr_ok(r_reg.awaddr) && r_reg.wlane0) begin
                unique case (wr_idx)
                    ctm_pkg::REG_CTL0:    r_next.ctl0[wr_t] = r_reg.wbyte;
                    ctm_pkg::REG_CTL1:    r_next.ctl1[wr_t] = r_reg.wbyte;
                    ctm_pkg::REG_CMPA_LO: r_next.hold[wr_t] = r_reg.wbyte;
                    ctm_pkg::REG_CMPA_HI: begin
                        r_next.cmpa[wr_t] = {r_reg.wbyte[1:0], r_reg.hold[wr_t]};
                    end
                    default:              r_next.hold[wr_t] = r_reg.hold[wr_t];
                endcase
            end
        end
        r_next.awready = !r_next.aw_held;
        r_next.wready  = !r_next.w_held;
        r_next.arready = !r_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= BUS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign awready = r_reg.awready;
    assign wready  = r_reg.wready;
    assign bvalid  = r_reg.bvalid;
    assign bresp   = r_reg.bresp;
    assign arready = r_reg.arready;
    assign rvalid  = r_reg.rvalid;
    assign rresp   = r_reg.rresp;
    assign rdata   = {24'h000000, r_reg.rbyte};

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_lo_write;
        wr_go && r_reg.wlane0 && addr_ok(r_reg.awaddr) && wr_idx == ctm_pkg::REG_CMPA_LO;
    endsequence
    sequence s_hi_write;
        wr_go && r_reg.wlane0 && addr_ok(r_reg.awaddr) && wr_idx == ctm_pkg::REG_CMPA_HI;
    endsequence

    chk_lo_write_buf:  assert property (s_lo_write |=> $stable(r_reg.cmpa)
                                        && r_reg.hold[$past(wr_t)] == $past(r_reg.wbyte))
        else $error("low byte write touched live value");
    chk_hi_write_copy: assert property (s_hi_write |=> r_reg.cmpa[$past(wr_t)]
                                        == {$past(r_reg.wbyte[1:0]), $past(r_reg.hold[wr_t])})
        else $error("high byte write did not copy holding byte");
    chk_hi_read_latch: assert property (rd_go && addr_ok(araddr) && rd_idx == ctm_pkg::REG_CNT_HI
                                        |=> r_reg.hold[$past(rd_t)] == $past(cnt_w[rd_t][7:0])
                                        && r_reg.rvalid)
        else $error("count high read did not latch low byte");
    chk_write_answer:  assert property (wr_go |=> r_reg.bvalid ##0 !r_reg.aw_held)
        else $error("write not answered next cycle");

endmodule
`default_nettype wire

// ### logic/ctm_pkg.sv
package ctm_pkg;

    // =========================================================
    // register map, per timer
    // =========================================================
    localparam int           TIMERS      = 2;
    localparam int           ADDR_W      = 8;
    localparam logic [2:0]   REG_CTL0    = 3'h0;
    localparam logic [2:0]   REG_CTL1    = 3'h1;
    localparam logic [2:0]   REG_CNT_LO  = 3'h2;
    localparam logic [2:0]   REG_CNT_HI  = 3'h3;
    localparam logic [2:0]   REG_CMPA_LO = 3'h4;
    localparam logic [2:0]   REG_CMPA_HI = 3'h5;
    localparam logic [1:0]   RESP_OKAY   = 2'h0;
    localparam logic [1:0]   RESP_SLVERR = 2'h2;

    // =========================================================
    // control byte 0 and 1 fields
    // =========================================================
    localparam int           C0_PAUSE    = 7;
    localparam int           C0_CK_LSB   = 4;
    localparam int           C0_ON       = 3;
    localparam int           C0_RP_LSB   = 0;
    localparam int           C1_MODE_LSB = 6;
    localparam int           C1_IO_LSB   = 4;
    localparam int           C1_OC       = 3;
    localparam int           C1_POL      = 2;
    localparam int           C1_DPX      = 1;
    localparam int           C1_CCLR     = 0;
    localparam logic [7:0]   CTL_RESET   = 8'h00;

    // =========================================================
    // counter constants
    // =========================================================
    localparam int           CNT_W       = 10;
    localparam int           RP_W        = 3;
    localparam logic [6:0]   P_LOW_ONES  = 7'h7F;

    typedef enum logic [2:0] {
        CK_SYS_DIV4 = 3'b000,
        CK_SYS      = 3'b001,
        CK_H_DIV16  = 3'b010,
        CK_H_DIV64  = 3'b011,
        CK_SUB_A    = 3'b100,
        CK_SUB_B    = 3'b101,
        CK_EXT_RISE = 3'b110,
        CK_EXT_FALL = 3'b111
    } clk_sel_e;

    typedef enum logic [1:0] {
        MODE_CMP  = 2'b00,
        MODE_UNDF = 2'b01,
        MODE_PWM  = 2'b10,
        MODE_TMR  = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        IO_NONE = 2'b00,
        IO_LOW  = 2'b01,
        IO_HIGH = 2'b10,
        IO_TOG  = 2'b11
    } io_e;

endpackage

// ### logic/timer_core.sv
`timescale 1ns/1ps
`default_nettype none
module timer_core (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pins
    input  wire logic ext_clk_pin,
    input  wire logic sub_clk_pin,
    // control and status
    timer_if.core     tif
);
    typedef struct packed {
        logic [9:0] cnt;
        logic       on_d;
        logic [5:0] pre;
        logic [2:0] ext_s;
        logic       ext_lvl;
        logic [2:0] sub_s;
        logic       sub_lvl;
        logic       out;
        logic       pin;
        logic       pin_n;
        logic       irq_a;
        logic       irq_p;
    } core_s;

    localparam core_s CORE_RESET = '{pin_n: 1'b1, default: '0};

    core_s r_reg;
    core_s r_next;
    logic  tick;
    logic  run;
    logic  match_a;
    logic  match_p;
    logic  clr_by_a;
    logic  active;

    wire logic       on    = tif.ctl0[ctm_pkg::C0_ON];
    wire logic       pause = tif.ctl0[ctm_pkg::C0_PAUSE];
    wire logic [2:0] rp    = tif.ctl0[ctm_pkg::C0_RP_LSB +: ctm_pkg::RP_W];
    wire logic       oc    = tif.ctl1[ctm_pkg::C1_OC];
    wire logic       dpx   = tif.ctl1[ctm_pkg::C1_DPX];
    wire ctm_pkg::clk_sel_e sel  = ctm_pkg::clk_sel_e'(tif.ctl0[ctm_pkg::C0_CK_LSB +: 3]);
    wire ctm_pkg::mode_e    mode = ctm_pkg::mode_e'(tif.ctl1[ctm_pkg::C1_MODE_LSB +: 2]);
    wire ctm_pkg::io_e      io   = ctm_pkg::io_e'(tif.ctl1[ctm_pkg::C1_IO_LSB +: 2]);

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        r_next       = r_reg;
        r_next.pre   = r_reg.pre + 6'h01;
        r_next.ext_s = {r_reg.ext_s[1:0], ext_clk_pin};
        r_next.sub_s = {r_reg.sub_s[1:0], sub_clk_pin};
        if (r_reg.ext_s[1] == r_reg.ext_s[2]) begin
            r_next.ext_lvl = r_reg.ext_s[2];
        end
        if (r_reg.sub_s[1] == r_reg.sub_s[2]) begin
            r_next.sub_lvl = r_reg.sub_s[2];
        end
        unique case (sel)
            ctm_pkg::CK_SYS_DIV4: tick = (r_reg.pre[1:0] == 2'h3);
            ctm_pkg::CK_SYS:      tick = 1'b1;
            ctm_pkg::CK_H_DIV16:  tick = (r_reg.pre[3:0] == 4'hF);
            ctm_pkg::CK_H_DIV64:  tick = (r_reg.pre == 6'h3F);
            ctm_pkg::CK_SUB_A,
            ctm_pkg::CK_SUB_B:    tick = r_next.sub_lvl & ~r_reg.sub_lvl;
            ctm_pkg::CK_EXT_RISE: tick = r_next.ext_lvl & ~r_reg.ext_lvl;
            ctm_pkg::CK_EXT_FALL: tick = ~r_next.ext_lvl & r_reg.ext_lvl;
        endcase
        run      = on & ~pause & tick;
        match_a  = (r_reg.cnt == tif.cmpa);
        match_p  = (r_reg.cnt == {rp - 3'h1, ctm_pkg::P_LOW_ONES});
        clr_by_a = (mode == ctm_pkg::MODE_PWM) ? dpx : tif.ctl1[ctm_pkg::C1_CCLR];
        active   = dpx ? (r_reg.cnt[9:7] < rp) : (r_reg.cnt < tif.cmpa);
        r_next.on_d  = on;
        r_next.irq_a = run & match_a;
        r_next.irq_p = run & match_p;
        if (on && !r_reg.on_d) begin
            r_next.cnt = '0;
            r_next.out = oc;
        end else if (run) begin
            if ((match_a && clr_by_a) || (match_p && !clr_by_a)) begin
                r_next.cnt = '0;
            end else begin
                r_next.cnt = r_reg.cnt + 10'h001;
            end
            if (mode == ctm_pkg::MODE_CMP && match_a) begin
                unique case (io)
                    ctm_pkg::IO_NONE: r_next.out = r_reg.out;
                    ctm_pkg::IO_LOW:  r_next.out = 1'b0;
                    ctm_pkg::IO_HIGH: r_next.out = 1'b1;
                    ctm_pkg::IO_TOG:  r_next.out = ~r_reg.out;
                endcase
            end
        end
        if (mode == ctm_pkg::MODE_PWM && r_reg.on_d) begin
            unique case (io)
                ctm_pkg::IO_NONE: r_next.out = ~oc;
                ctm_pkg::IO_LOW:  r_next.out = oc;
                ctm_pkg::IO_HIGH: r_next.out = active ? oc : ~oc;
                default:          r_next.out = r_reg.out;
            endcase
        end
        if (mode != ctm_pkg::MODE_TMR) begin
            r_next.pin = r_next.out ^ tif.ctl1[ctm_pkg::C1_POL];
        end
        r_next.pin_n = ~r_next.pin;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= CORE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tif.cnt   = r_reg.cnt;
    assign tif.irq_a = r_reg.irq_a;
    assign tif.irq_p = r_reg.irq_p;
    assign tif.pin   = r_reg.pin;
    assign tif.pin_n = r_reg.pin_n;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_on_rise;
        on && !r_reg.on_d;
    endsequence
    sequence s_cleared;
        r_reg.cnt == 10'h000;
    endsequence

    chk_on_clear:    assert property (s_on_rise |=> s_cleared)
        else $error("counter not cleared on enable");
    chk_pin_inverse: assert property (r_reg.pin_n == ~r_reg.pin)
        else $error("inverted pin does not mirror");
    chk_pause_hold:  assert property (r_reg.on_d && on && pause |=> $stable(r_reg.cnt))
        else $error("counter moved while paused");
    chk_count_step:  assert property (run && r_reg.on_d && !match_a && !match_p
                                      |=> r_reg.cnt == $past(r_reg.cnt) + 10'h001)
        else $error("counter did not step by one");
    chk_p_clear:     assert property (run && r_reg.on_d && match_p && !clr_by_a
                                      |=> s_cleared ##0 r_reg.irq_p)
        else $error("period match did not clear and flag");
    chk_set_high:    assert property (run && r_reg.on_d && match_a && mode == ctm_pkg::MODE_CMP
                                      && io == ctm_pkg::IO_HIGH |=> r_reg.out)
        else $error("compare match did not drive high");
    chk_ext_rise:    assert property (on && !pause && sel == ctm_pkg::CK_EXT_RISE
                                      && r_reg.ext_s[2:1] == 2'b11 && !r_reg.ext_lvl |-> run)
        else $error("external rising edge missed");

endmodule
`default_nettype wire

// ### logic/timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [9:0] cmpa;
    logic [9:0] cnt;
    logic       irq_a;
    logic       irq_p;
    logic       pin;
    logic       pin_n;
    modport ctl  (output ctl0, ctl1, cmpa, input cnt, irq_a, irq_p, pin, pin_n);
    modport core (input ctl0, ctl1, cmpa, output cnt, irq_a, irq_p, pin, pin_n);
endinterface
`default_nettype wire

// ### verification/compact_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module compact_timer_tb;
    // ==========================================
    // signals
    // ==========================================
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    wire logic   awready, wready, bvalid, arready, rvalid, sub_clock_pin;
    wire logic [1:0]  bresp, rresp, external_clock_pin, timer_output_pin;
    wire logic [1:0]  timer_output_pin_inverted, compare_a_irq, period_irq;
    wire logic [31:0] rdata;
    int          errors = 0, n_tests = 0, cycles = 0, n;
    logic [1:0]  resp;
    logic [31:0] rd;
    logic [9:0]  cv, cv2;
    logic        p1;
    int          rps[3] = '{1, 2, 0};
    int          cks[4] = '{0, 2, 3, 4};
    int          dvs[4] = '{4, 16, 64, 8};
    typedef struct packed {
        logic w; logic [7:0] a; logic [7:0] d; logic [1:0] r; logic [7:0] q;
    } row_s;
    row_s rows[9] = '{
        '{1'b1, 8'h04, 8'hA5, 2'h0, 8'h00}, '{1'b0, 8'h04, 8'h00, 2'h0, 8'hA5},
        '{1'b1, 8'h20, 8'h77, 2'h0, 8'h00}, '{1'b0, 8'h20, 8'h00, 2'h0, 8'h77},
        '{1'b1, 8'h08, 8'hFF, 2'h0, 8'h00}, '{1'b0, 8'h0C, 8'h00, 2'h0, 8'h00},
        '{1'b1, 8'h18, 8'h12, 2'h2, 8'h00}, '{1'b0, 8'h18, 8'h00, 2'h2, 8'h00},
        '{1'b0, 8'h41, 8'h00, 2'h2, 8'h00}};

    always #2 aclk = ~aclk;

    compact_timer i_compact_timer (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .external_clock_pin,
        .sub_clock_pin, .timer_output_pin, .timer_output_pin_inverted,
        .compare_a_irq, .period_irq);
    ext_clock_source i_ext_clock_source (.aclk, .external_clock_pin, .sub_clock_pin);

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================
    // bus and helper tasks
    // ==========================================
    function automatic logic [7:0] ra(input int t, input logic [2:0] i);
        return 8'(32 * t + 4 * i);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        resp = rresp;
        rd = rdata;
        rready <= 1'b0;
    endtask

    // high byte first, low byte comes from the holding byte
    task automatic rdc(input int t);
        rdr(ra(t, ctm_pkg::REG_CNT_HI));
        cv[9:8] = rd[1:0];
        rdr(ra(t, ctm_pkg::REG_CNT_LO));
        cv[7:0] = rd[7:0];
    endtask

    task automatic wirq(input int t, input bit a);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!(a ? compare_a_irq[t] : period_irq[t]) && n < 3000);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // tests
    // ==========================================
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("pin", 2'h0, timer_output_pin);
        `CHK("pin_n", 2'h3, timer_output_pin_inverted);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
                `CHK("bresp", rows[i].r, resp);
            end else begin
                rdr(rows[i].a);
                `CHK("rresp", rows[i].r, resp);
                `CHK("rdata", {24'h0, rows[i].q}, rd);
            end
        end
        $display("register table done");
        wr(ra(0, 4), 8'h55);
        rdr(ra(0, 5));
        rdr(ra(0, 4));
        `CHK("cmpa lo held", 32'h0, rd);
        wr(ra(0, 4), 8'h55);
        wr(ra(0, 5), 8'h02);
        rdr(ra(0, 5));
        `CHK("cmpa hi", 32'h2, rd);
        rdr(ra(0, 4));
        `CHK("cmpa lo", 32'h55, rd);
        $display("holding byte done");
        wr(ra(0, 1), 8'h31);
        wr(ra(0, 4), 8'h14);
        wr(ra(0, 5), 8'h00);
        wr(ra(0, 0), 8'h18);
        wirq(0, 1);
        wirq(0, 1);
        `CHK("a gap", 21, n);
        repeat (2) @(posedge aclk);
        p1 = timer_output_pin[0];
        wirq(0, 1);
        repeat (2) @(posedge aclk);
        `CHK("toggle", ~p1, timer_output_pin[0]);
        `CHK("inverse", ~timer_output_pin, timer_output_pin_inverted);
        wr(ra(0, 0), 8'h10);
        wr(ra(0, 1), 8'h21);
        wr(ra(0, 0), 8'h18);
        @(posedge aclk);
        `CHK("initial low", 1'b0, timer_output_pin[0]);
        wirq(0, 1);
        repeat (2) @(posedge aclk);
        `CHK("set high", 1'b1, timer_output_pin[0]);
        wr(ra(0, 0), 8'h10);
        $display("compare output done");
        // compare A at zero clears every tick: irq gap is the divider
        wr(ra(1, 1), 8'hC1);
        foreach (dvs[i]) begin
            wr(ra(1, 0), 8'(cks[i] * 16));
            wr(ra(1, 0), 8'(8'h08 | cks[i] * 16));
            wirq(1, 1);
            wirq(1, 1);
            `CHK("div gap", dvs[i], n);
        end
        wr(ra(1, 1), 8'hC0);
        for (int i = 0; i < 3; i++) begin
            wr(ra(1, 0), 8'(8'h10 | rps[i]));
            wr(ra(1, 0), 8'(8'h18 | rps[i]));
            wirq(1, 0);
            wirq(1, 0);
            `CHK("p gap", (rps[i] != 0) ? 128 * rps[i] : 1024, n);
        end
        wr(ra(1, 0), 8'h98);
        rdc(1);
        cv2 = cv;
        repeat (20) @(posedge aclk);
        rdc(1);
        `CHK("paused", cv2, cv);
        wr(ra(1, 0), 8'h18);
        repeat (20) @(posedge aclk);
        rdc(1);
        `CHK("resumed", 1'b1, cv != cv2 && 10'(cv - cv2) < 10'd100);
        $display("period and pause done");
        wr(ra(1, 0), 8'h10);
        wr(ra(1, 4), 8'h40);
        wr(ra(1, 5), 8'h00);
        wr(ra(1, 1), 8'hA8);
        wr(ra(1, 0), 8'h19);
        wirq(1, 0);
        n = 0;
        repeat (128) begin
            @(posedge aclk);
            n += timer_output_pin[1];
        end
        `CHK("pwm duty", 64, n);
        $display("pwm done");
        wr(ra(0, 1), 8'hC0);
        for (int e = 0; e < 2; e++) begin
            wr(ra(0, 0), 8'(8'h60 | e * 16));
            wr(ra(0, 0), 8'(8'h68 | e * 16));
            @(posedge aclk);
            i_ext_clock_source.pulse(0, 3 + e);
            repeat (10) @(posedge aclk);
            rdc(0);
            `CHK("ext count", 10'(3 + e), cv);
        end
        wr(ra(0, 0), 8'h70);
        rdc(0);
        `CHK("retained", 10'h4, cv);
        wr(ra(0, 0), 8'h78);
        rdc(0);
        `CHK("cleared", 10'h0, cv);
        $display("external clock done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(ra(1, 0));
        `CHK("ctl after reset", 32'h0, rd);
        $display("reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### verification/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external event source and sub clock
// ==========================================
module ext_clock_source (
    // clock
    input  wire logic       aclk,
    // pins
    output logic [1:0]      external_clock_pin,
    output logic            sub_clock_pin
);
    initial begin
        external_clock_pin = 2'h0;
        sub_clock_pin = 1'b0;
    end

    // sub clock runs free
    always begin
        repeat (4) @(posedge aclk);
        sub_clock_pin <= ~sub_clock_pin;
    end

    // clock pin idles low between bursts, each pulse gives one counted edge of the external clock
    task automatic pulse(input int t, input int n);
        repeat (n) begin
            external_clock_pin[t] <= 1'b1;
            repeat (6) @(posedge aclk);
            external_clock_pin[t] <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask
endmodule
`default_nettype wire
